// ---- shared/mpio_cfg.svh ----
`ifndef MPIO_CFG_SVH
`define MPIO_CFG_SVH
`define MPIO_SMALL_W 3
`define MPIO_WIDE_W 8
`define MPIO_SMALL_LATCH_RST 3'h7
`define MPIO_WIDE_RST 8'h00
`define MPIO_ANALOG_INPUT_DISABLE_BIT_RST 1'b1
`define MPIO_SEL_SMALL 2'h0
`define MPIO_SEL_FIRST 2'h1
`define MPIO_SEL_SECOND 2'h2
`define MPIO_SEL_ANALOG 2'h3
`define MPIO_UNDEF_FILL 5'h00
`endif

// ---- shared/mpio_pkg.sv ----
package mpio_pkg;
  typedef enum logic [1:0] {
    MPIO_PORT_SMALL = 2'h0,
    MPIO_PORT_FIRST = 2'h1,
    MPIO_PORT_SECOND = 2'h2,
    MPIO_PORT_ANALOG = 2'h3
  } mpio_port_type;
  typedef enum logic [3:0] {
    MPIO_WR_LATCH = 4'h1,
    MPIO_WR_DIR = 4'h2,
    MPIO_WR_ODE = 4'h4,
    MPIO_WR_ANALOG_INPUT_DISABLE_BIT = 4'h8
  } mpio_wr_type;
endpackage : mpio_pkg

// ---- rtl/mpio_block.sv ----
`timescale 1ns/10ps
`include "mpio_cfg.svh"
// Contract
// - Small port is three bits; latch resets to all ones.
// - Small-port read bits 7 to 3 are undefined.
// - Small port: RMW reads latch, other reads sample pins.
// - Falling edge on stop pin driven as output sets interrupt latch.
// - Stop pin floats in stop mode regardless of stop output enable.
// - First wide port resets direction and latch to zero.
// - First wide port open-drain select resets to zero, push-pull.
// - Open-drain ports: RMW in open-drain reads latch, else pins.
// - Second wide port resets direction and latch to zero.
// - Second wide port open-drain select resets to zero.
// - Analog port resets dir, latch 0, disable 1; inputs read 0.
// - Channel comes from converter select, not port bits.
// - Analog port bit with latch 0 reads 0.
// - Analog-configured bits always read 0.
// - Analog port RMW reads pins ANDed with latch and writes all eight back.
module mpio_block (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] wr_port,
  input wire logic [3:0] wr_kind,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [1:0] rd_port,
  input wire logic rd_rmw,
  input wire logic stop_mode,
  input wire logic stop_output_enable_bit,
  input wire logic [2:0] small_port_in,
  input wire logic [7:0] first_wide_in,
  input wire logic [7:0] second_wide_in,
  input wire logic [7:0] analog_port_in,
  output logic [7:0] rd_data,
  output logic [2:0] small_port_out,
  output logic [2:0] small_port_oe,
  output logic [7:0] first_wide_out,
  output logic [7:0] first_wide_oe,
  output logic [7:0] second_wide_out,
  output logic [7:0] second_wide_oe,
  output logic [7:0] analog_port_out,
  output logic [7:0] analog_port_oe,
  output logic [7:0] analog_enable,
  output logic stop_pin_irq
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sm_s1_q, sm_s2_q;
  logic [7:0] fw_s1_q, fw_s2_q, sw_s1_q, sw_s2_q, an_s1_q, an_s2_q;
  logic stop_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sm_s1_q <= 3'h7;
      sm_s2_q <= 3'h7;
      fw_s1_q <= 8'h00;
      fw_s2_q <= 8'h00;
      sw_s1_q <= 8'h00;
      sw_s2_q <= 8'h00;
      an_s1_q <= 8'h00;
      an_s2_q <= 8'h00;
    end else begin
      sm_s1_q <= small_port_in;
      sm_s2_q <= sm_s1_q;
      fw_s1_q <= first_wide_in;
      fw_s2_q <= fw_s1_q;
      sw_s1_q <= second_wide_in;
      sw_s2_q <= sw_s1_q;
      an_s1_q <= analog_port_in;
      an_s2_q <= an_s1_q;
    end
  end

  // ----------------------------------------
  // Latches and control bits
  // ----------------------------------------
  logic [2:0] sm_latch_q, sm_dir_q;
  logic [7:0] fw_latch_q, fw_dir_q, fw_ode_q;
  logic [7:0] sw_latch_q, sw_dir_q, sw_ode_q;
  logic [7:0] an_latch_q, an_dir_q;
  logic analog_input_disable_bit_q;
  function automatic logic hit(input logic [1:0] p, input logic [3:0] k,
                               input logic [1:0] tp, input logic [3:0] tk);
    hit = (p == tp) && ((k & tk) != 4'h0);
  endfunction : hit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sm_latch_q <= `MPIO_SMALL_LATCH_RST;
      sm_dir_q <= 3'h0;
      fw_latch_q <= `MPIO_WIDE_RST;
      fw_dir_q <= `MPIO_WIDE_RST;
      fw_ode_q <= `MPIO_WIDE_RST;
      sw_latch_q <= `MPIO_WIDE_RST;
      sw_dir_q <= `MPIO_WIDE_RST;
      sw_ode_q <= `MPIO_WIDE_RST;
      an_latch_q <= `MPIO_WIDE_RST;
      an_dir_q <= `MPIO_WIDE_RST;
      analog_input_disable_bit_q <= `MPIO_ANALOG_INPUT_DISABLE_BIT_RST;
    end else begin
      // A write of all eight bits is also how an RMW lands on the analog port
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_SMALL, mpio_pkg::MPIO_WR_LATCH))
        sm_latch_q <= wr_data[2:0];
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_SMALL, mpio_pkg::MPIO_WR_DIR))
        sm_dir_q <= wr_data[2:0];
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_FIRST, mpio_pkg::MPIO_WR_LATCH))
        fw_latch_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_FIRST, mpio_pkg::MPIO_WR_DIR))
        fw_dir_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_FIRST, mpio_pkg::MPIO_WR_ODE))
        fw_ode_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_SECOND, mpio_pkg::MPIO_WR_LATCH))
        sw_latch_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_SECOND, mpio_pkg::MPIO_WR_DIR))
        sw_dir_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_SECOND, mpio_pkg::MPIO_WR_ODE))
        sw_ode_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_ANALOG, mpio_pkg::MPIO_WR_LATCH))
        an_latch_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_ANALOG, mpio_pkg::MPIO_WR_DIR))
        an_dir_q <= wr_data;
      if (hit(wr_port, wr_kind, mpio_pkg::MPIO_PORT_ANALOG, mpio_pkg::MPIO_WR_ANALOG_INPUT_DISABLE_BIT))
        analog_input_disable_bit_q <= wr_data[0];
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  function automatic logic [7:0] drv_oe(input logic [7:0] dir, input logic [7:0] ode,
                                        input logic [7:0] lat);
    drv_oe = dir & ~(ode & lat);
  endfunction : drv_oe
  function automatic logic [7:0] drv_out(input logic [7:0] ode, input logic [7:0] lat);
    drv_out = lat & ~ode;
  endfunction : drv_out
  function automatic logic [7:0] an_link(input logic dis, input logic [7:0] dir,
                                         input logic [7:0] lat);
    an_link = {8{~dis}} & ~dir & ~lat;
  endfunction : an_link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      small_port_out <= 3'h0;
      small_port_oe <= 3'h0;
      first_wide_out <= 8'h00;
      first_wide_oe <= 8'h00;
      second_wide_out <= 8'h00;
      second_wide_oe <= 8'h00;
      analog_port_out <= 8'h00;
      analog_port_oe <= 8'h00;
      analog_enable <= 8'h00;
    end else begin
      small_port_out <= sm_latch_q;
      small_port_oe <= {sm_dir_q[2:1] & {2{~stop_mode | stop_output_enable_bit}},
                        sm_dir_q[0] & ~stop_mode};
      first_wide_out <= drv_out(fw_ode_q, fw_latch_q);
      first_wide_oe <= drv_oe(fw_dir_q, fw_ode_q, fw_latch_q);
      second_wide_out <= drv_out(sw_ode_q, sw_latch_q);
      second_wide_oe <= drv_oe(sw_dir_q, sw_ode_q, sw_latch_q);
      analog_port_out <= an_latch_q;
      analog_port_oe <= an_dir_q;
      // Analog path per bit; channel choice stays with the converter
      analog_enable <= an_link(analog_input_disable_bit_q, an_dir_q, an_latch_q);
    end
  end

  // ----------------------------------------
  // Stop pin falling edge
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_prev_q <= 1'b1;
      stop_pin_irq <= 1'b0;
    end else begin
      stop_prev_q <= sm_s2_q[0];
      stop_pin_irq <= stop_prev_q & ~sm_s2_q[0];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] an_rd;
  assign an_rd = an_s2_q & an_latch_q & ~an_link(analog_input_disable_bit_q, an_dir_q, an_latch_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (rd_port)
        mpio_pkg::MPIO_PORT_SMALL:
          rd_data <= {`MPIO_UNDEF_FILL, rd_rmw ? sm_latch_q : sm_s2_q};
        mpio_pkg::MPIO_PORT_FIRST:
          rd_data <= (rd_rmw ? (fw_ode_q & fw_latch_q) : 8'h00)
                   | (fw_s2_q & ~(rd_rmw ? fw_ode_q : 8'h00));
        mpio_pkg::MPIO_PORT_SECOND:
          rd_data <= (rd_rmw ? (sw_ode_q & sw_latch_q) : 8'h00)
                   | (sw_s2_q & ~(rd_rmw ? sw_ode_q : 8'h00));
        default:
          rd_data <= an_rd;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rst_exit;
    $rose(rst_n);
  endsequence
  property p_small_rst;
    @(posedge clk) s_rst_exit |=> small_port_out == `MPIO_SMALL_LATCH_RST;
  endproperty
  a_small_rst: assert property (p_small_rst) else $error("small latch reset");
  property p_wide_rst;
    @(posedge clk) s_rst_exit |=> first_wide_oe == 8'h00 && first_wide_out == 8'h00
      && second_wide_oe == 8'h00 && second_wide_out == 8'h00;
  endproperty
  a_wide_rst: assert property (p_wide_rst) else $error("wide port reset");
  property p_ode_rst;
    @(posedge clk) s_rst_exit |=> fw_ode_q == 8'h00 && sw_ode_q == 8'h00;
  endproperty
  a_ode_rst: assert property (p_ode_rst) else $error("open drain select reset");
  property p_an_rst;
    @(posedge clk) s_rst_exit |=> analog_input_disable_bit_q && analog_port_oe == 8'h00
      && analog_port_out == 8'h00 && analog_enable == 8'h00;
  endproperty
  a_an_rst: assert property (p_an_rst) else $error("analog port reset");
  property p_small_upper;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h0 |=> rd_data[7:3] == 5'h00;
  endproperty
  a_small_upper: assert property (p_small_upper) else $error("small upper bits");
  property p_small_rmw;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h0 && rd_rmw |=> rd_data[2:0] == $past(sm_latch_q);
  endproperty
  a_small_rmw: assert property (p_small_rmw) else $error("small rmw not latch");
  property p_small_pins;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h0 && !rd_rmw |=> rd_data[2:0] == $past(sm_s2_q);
  endproperty
  a_small_pins: assert property (p_small_pins) else $error("small read not pins");
  sequence s_fall;
    sm_s2_q[0] ##1 !sm_s2_q[0];
  endsequence
  property p_stop_irq;
    @(posedge clk) disable iff (!rst_n) s_fall |=> stop_pin_irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("falling edge missed");
  property p_irq_pulse;
    @(posedge clk) disable iff (!rst_n) stop_pin_irq |=> !stop_pin_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
  property p_stop_float;
    @(posedge clk) disable iff (!rst_n) stop_mode |=> !small_port_oe[0];
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("stop pin driven");
  property p_stop_gate;
    @(posedge clk) disable iff (!rst_n)
      stop_mode && !stop_output_enable_bit |=> small_port_oe == 3'h0;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("small port driven in stop");
  property p_od_high;
    @(posedge clk) disable iff (!rst_n)
      fw_ode_q[0] && fw_latch_q[0] |=> !first_wide_oe[0];
  endproperty
  a_od_high: assert property (p_od_high) else $error("open drain drives high");
  property p_od_low;
    @(posedge clk) disable iff (!rst_n)
      fw_dir_q[4] && fw_ode_q[4] && !fw_latch_q[4] |=> first_wide_oe[4] && !first_wide_out[4];
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain not low");
  property p_no_dir;
    @(posedge clk) disable iff (!rst_n)
      !fw_dir_q[2] |=> !first_wide_oe[2];
  endproperty
  a_no_dir: assert property (p_no_dir) else $error("input pin driven");
  property p_dir_drive;
    @(posedge clk) disable iff (!rst_n)
      sw_dir_q[1] && !sw_ode_q[1] |=> second_wide_oe[1]
        && second_wide_out[1] == $past(sw_latch_q[1]);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("dir not driving");
  property p_wide_rmw;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h2 && rd_rmw && sw_ode_q[3] |=> rd_data[3] == $past(sw_latch_q[3]);
  endproperty
  a_wide_rmw: assert property (p_wide_rmw) else $error("od rmw not latch");
  property p_fw_pins;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h1 && !rd_rmw |=> rd_data == $past(fw_s2_q);
  endproperty
  a_fw_pins: assert property (p_fw_pins) else $error("wide read not pins");
  property p_an_zero;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h3 && !an_latch_q[2] |=> !rd_data[2];
  endproperty
  a_an_zero: assert property (p_an_zero) else $error("analog bit not zero");
  property p_an_link;
    @(posedge clk) disable iff (!rst_n)
      rd_en && rd_port == 2'h3 && !analog_input_disable_bit_q && !an_dir_q[5] && !an_latch_q[5]
        |=> !rd_data[5];
  endproperty
  a_an_link: assert property (p_an_link) else $error("analog input not zero");
  property p_an_enable;
    @(posedge clk) disable iff (!rst_n)
      !analog_input_disable_bit_q && !an_dir_q[0] && !an_latch_q[0] |=> analog_enable[0];
  endproperty
  a_an_enable: assert property (p_an_enable) else $error("analog path not enabled");
  property p_an_rmw_wb;
    @(posedge clk) disable iff (!rst_n)
      wr_port == 2'h3 && wr_kind[0] |=> an_latch_q == $past(wr_data);
  endproperty
  a_an_rmw_wb: assert property (p_an_rmw_wb) else $error("analog write back lost");
endmodule : mpio_block

// ---- verif/mpio_pad_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Far-side pad: released bits follow the outside source
// ----------------------------------------
module mpio_pad_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  assign pin = (oe & out) | (~oe & ext);
endmodule : mpio_pad_model

// ---- verif/mpio_block_bench.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module mpio_block_bench;
  logic clk = 1'b0;
  logic rst_n, rd_en, rd_rmw, stop_mode, stop_output_enable_bit, stop_pin_irq, dis;
  logic [1:0] wr_port, rd_port;
  logic [3:0] wr_kind;
  logic [7:0] wr_data, rd_data, first_wide_out, first_wide_oe, second_wide_out;
  logic [7:0] second_wide_oe, analog_port_out, analog_port_oe, analog_enable, pin1, pin2, pin3;
  logic [2:0] small_port_out, small_port_oe, pin0;
  logic [7:0] ext [4];
  logic [7:0] lat [4];
  logic [7:0] dir [4];
  logic [7:0] ode [4];
  int miscompares, num_checks, cycles, irqs, p;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (stop_pin_irq === 1'b1) irqs++;
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end
  mpio_block DUT (.clk, .rst_n, .wr_port, .wr_kind, .wr_data, .rd_en, .rd_port, .rd_rmw,
    .stop_mode, .stop_output_enable_bit, .small_port_in(pin0), .first_wide_in(pin1),
    .second_wide_in(pin2), .analog_port_in(pin3), .rd_data, .small_port_out, .small_port_oe,
    .first_wide_out, .first_wide_oe, .second_wide_out, .second_wide_oe, .analog_port_out,
    .analog_port_oe, .analog_enable, .stop_pin_irq);
  mpio_pad_model #(.W(3)) pad0 (.oe(small_port_oe), .out(small_port_out), .ext(ext[0][2:0]),
    .pin(pin0));
  mpio_pad_model pad1 (.oe(first_wide_oe), .out(first_wide_out), .ext(ext[1]), .pin(pin1));
  mpio_pad_model pad2 (.oe(second_wide_oe), .out(second_wide_out), .ext(ext[2]), .pin(pin2));
  mpio_pad_model pad3 (.oe(analog_port_oe), .out(analog_port_out), .ext(ext[3]), .pin(pin3));
  // ----------------------------------------
  // Expected drive and read values
  // ----------------------------------------
  function automatic logic [7:0] eoe(input int q);
    eoe = dir[q] & ~(ode[q] & lat[q]);
  endfunction : eoe
  function automatic logic [15:0] edrv(input int q);
    edrv = {eoe(q), eoe(q) & lat[q]};
  endfunction : edrv
  function automatic logic [7:0] erd(input int q, input logic rmw);
    logic [7:0] w;
    w = (eoe(q) & lat[q]) | (~eoe(q) & ext[q]);
    case (q)
      0: erd = rmw ? lat[0] : w & 8'h07;
      3: erd = w & lat[3];
      default: erd = rmw ? (ode[q] & lat[q]) | (~ode[q] & w) : w;
    endcase
  endfunction : erd
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input int q, input logic [3:0] k, input logic [7:0] d);
    logic [7:0] m;
    m = (q == 0) ? 8'h07 : 8'hff;
    @(posedge clk);
    wr_port <= q[1:0];
    wr_kind <= k;
    wr_data <= d;
    @(posedge clk);
    wr_kind <= 4'h0;
    if (k[0]) lat[q] = d & m;
    if (k[1]) dir[q] = d & m;
    if (k[2]) ode[q] = d;
    if (k[3]) dis = d[0];
    repeat (6) @(posedge clk);
  endtask : wr
  task automatic rd(input int q, input logic rmw);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_port <= q[1:0];
    rd_rmw <= rmw;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK(rd_data, erd(q, rmw))
  endtask : rd
  task automatic chk_pins();
    @(negedge clk);
    `CHK({5'h00, small_port_oe, 5'h00, small_port_out & small_port_oe}, edrv(0))
    `CHK({first_wide_oe, first_wide_out & first_wide_oe}, edrv(1))
    `CHK({second_wide_oe, second_wide_out & second_wide_oe}, edrv(2))
    `CHK({analog_port_oe, analog_port_out & analog_port_oe}, edrv(3))
    `CHK(analog_enable, ~{8{dis}} & ~dir[3] & ~lat[3])
  endtask : chk_pins
  task automatic stop_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, wr_port, wr_kind, wr_data, rd_en, rd_port, rd_rmw} = '0;
    {stop_mode, stop_output_enable_bit, dis} = 3'b001;
    for (int j = 0; j < 4; j++) begin
      ext[j] = (j == 0) ? 8'h07 : 8'h00;
      dir[j] = 8'h00;
      ode[j] = 8'h00;
      lat[j] = (j == 0) ? 8'h07 : 8'h00;
    end
    void'($urandom(11368));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk_pins();
    rd(0, 1'b1);
    ext[3] = 8'hff;
    rd(3, 1'b0);
    wr(1, 4'h3, 8'h0f);
    wr(1, 4'h4, 8'h33);
    chk_pins();
    rd(1, 1'b1);
    wr(3, 4'hb, 8'h00);
    chk_pins();
    rd(3, 1'b0);
    ext[0] = 8'h05;
    ext[3] = 8'h5a;
    wr(0, 4'h1, 8'h07);
    rd(0, 1'b0);
    wr(1, 4'h1, 8'hff);
    wr(2, 4'h2, 8'h80);
    wr(3, 4'h1, 8'hff);
    wr(3, 4'h2, 8'h0f);
    chk_pins();
    rd(3, 1'b0);
    repeat (150) begin
      @(posedge clk);
      for (int j = 0; j < 4; j++) ext[j] <= 8'($urandom);
      stop_output_enable_bit <= 1'($urandom);
      p = $urandom_range(0, 3);
      wr(p, 4'($urandom_range(1, 3)) | ((p == 1 || p == 2) ? 4'h4 : 4'h0)
        | ((p == 3) ? {1'($urandom), 3'h0} : 4'h0), 8'($urandom));
      chk_pins();
      rd($urandom_range(0, 3), 1'($urandom));
    end
    ext[0] <= 8'h07;
    wr(0, 4'h3, 8'h07);
    stop_output_enable_bit <= 1'b1;
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(small_port_oe[0], 1'b0)
    `CHK(small_port_oe[2:1], 2'h3)
    @(posedge clk);
    stop_output_enable_bit <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(small_port_oe, 3'h0)
    @(posedge clk);
    stop_mode <= 1'b0;
    repeat (6) @(posedge clk);
    irqs = 0;
    wr(0, 4'h1, 8'h06);
    repeat (4) @(posedge clk);
    `CHK(irqs, 1)
    stop_test();
  end
endmodule : mpio_block_bench
